// >>> tpu_pkg.sv
// Package for the trap priority unit: trap types, register map, field layout, carriers.
// Assumes one 50 MHz core clock; register map reached over classic Wishbone, 32-bit data.
package tpu_pkg;

  // Trap type codes
  localparam logic [7:0] TT_WRITE_ERR   = 8'h2B;
  localparam logic [7:0] TT_FETCH_ERR   = 8'h01;
  localparam logic [7:0] TT_ILLEGAL     = 8'h02;
  localparam logic [7:0] TT_PRIV        = 8'h03;
  localparam logic [7:0] TT_FP_DIS      = 8'h04;
  localparam logic [7:0] TT_CP_DIS      = 8'h24;
  localparam logic [7:0] TT_WATCH       = 8'h0B;
  localparam logic [7:0] TT_WIN_OVF     = 8'h05;
  localparam logic [7:0] TT_WIN_UNF     = 8'h06;
  localparam logic [7:0] TT_REG_ERR     = 8'h20;
  localparam logic [7:0] TT_ALIGN       = 8'h07;
  localparam logic [7:0] TT_FP_EXC      = 8'h08;
  localparam logic [7:0] TT_DATA_ERR    = 8'h09;
  localparam logic [7:0] TT_TAG_OVF     = 8'h0A;
  localparam logic [7:0] TT_DIV_ZERO    = 8'h2A;
  localparam logic [7:0] TT_IRQ_BASE    = 8'h10;
  localparam logic [7:0] TT_SOFT_BASE   = 8'h80;

  // Floating-point trap kinds
  localparam logic [2:0] FTT_NONE       = 3'h0;
  localparam logic [2:0] FTT_IEEE       = 3'h1;
  localparam logic [2:0] FTT_UNFINISHED = 3'h2;
  localparam logic [2:0] FTT_UNIMP      = 3'h3;
  localparam logic [2:0] FTT_SEQ        = 3'h4;

  localparam logic [3:0] IRQ_NMI_LEVEL  = 4'hF;
  localparam logic [1:0] SIZE_WORD      = 2'h2;

  // Register byte offsets
  localparam logic [7:0] OFS_TRAP_BASE  = 8'h00;
  localparam logic [7:0] OFS_WINDOW     = 8'h04;
  localparam logic [7:0] OFS_WIN_MASK   = 8'h08;
  localparam logic [7:0] OFS_PROC_STATE = 8'h0C;
  localparam logic [7:0] OFS_FP_STATE   = 8'h10;
  localparam logic [7:0] OFS_IRQ_PEND   = 8'h14;
  localparam logic [7:0] OFS_IRQ_FORCE  = 8'h18;
  localparam logic [7:0] OFS_IRQ_LEVEL  = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h20;
  localparam logic [7:0] OFS_WATCH      = 8'h24;
  localparam logic [7:0] OFS_STATUS     = 8'h28;

  // Field positions
  localparam int TRAP_TYPE_FIELD_LSB   = 4;
  localparam int TBR_BASE_LSB = 12;
  localparam int PS_SUPER_BIT = 0;
  localparam int PS_FP_EN_BIT = 1;
  localparam int PS_PIL_LSB   = 8;
  localparam int FS_FTT_LSB   = 8;
  localparam int ST_LVL_LSB   = 8;

  typedef struct packed {
    logic        instr_valid;
    logic        boundary;
    logic        wr_buf_err;
    logic        fetch_err;
    logic        illegal_op;
    logic        priv_op;
    logic        fp_op;
    logic        cp_op;
    logic        save_op;
    logic        restore_op;
    logic        reg_err;
    logic        mem_op;
    logic        jmp_op;
    logic [1:0]  mem_size;
    logic [31:0] mem_addr;
    logic [31:0] fetch_addr;
    logic [4:0]  fp_ieee_exc;
    logic        fp_unimp;
    logic        fp_unfinished;
    logic        fp_seq_err;
    logic        data_err;
    logic        tag_op;
    logic        tag_ovf;
    logic [1:0]  tag_a;
    logic [1:0]  tag_b;
    logic        div_op;
    logic [31:0] divisor;
    logic        ticc_op;
    logic        ticc_true;
    logic [6:0]  ticc_num;
    logic [31:0] pc;
    logic [31:0] next_program_counter;
  } tpu_event_s;

  typedef struct packed {
    logic        taken;
    logic        is_reset;
    logic        is_irq;
    logic [7:0]  tt;
    logic [31:0] vector;
    logic [31:0] pc;
    logic [31:0] next_program_counter;
  } tpu_trap_s;

endpackage

// >>> tpu_trap_unit.sv
// Trap priority unit: classifies traps, picks one, vectors it and selects interrupts.
// Assumes the pipeline presents one instruction's events per cycle, synchronous to core_clk_i.
// Notes on behaviour
// RULE1: Every trap vectors to the trap table at the base, entry chosen by type; the reset trap vectors to the base itself (entry 0).
// RULE2: Taking a trap moves the window pointer on and saves both program counters.
// RULE3: Synchronous traps during their instruction; interrupts only between instructions.
// RULE4: Of simultaneous synchronous traps only the highest priority one is taken.
// RULE5: A reset trap, top priority, follows release of the processor reset.
// RULE6: A reset trap leaves the trap type field untouched.
// RULE7: Buffered store error raises type 0x2B, priority 2.
// RULE8: Instruction fetch error raises type 0x01, priority 3.
// RULE9: Unimplemented or illegal instruction raises type 0x02, priority 5.
// RULE10: Privileged instruction outside supervisor mode raises type 0x03, priority 4.
// RULE11: Floating-point instruction with unit disabled raises type 0x04, priority 6.
// RULE12: Every co-processor instruction raises type 0x24.
// RULE13: Fetch or data address hitting the active watchpoint raises type 0x0B, priority 7.
// RULE14: SAVE into invalid window gives 0x05; RESTORE or RETT gives 0x06; priority 8.
// RULE15: Register file uncorrectable error raises type 0x20, priority 9.
// RULE16: Misaligned access or jump target raises type 0x07, priority 10.
// RULE17: Floating-point exceptions raise type 0x08, priority 11, kind recorded.
// RULE18: Data access error raises type 0x09, priority 13.
// RULE19: Tagged arithmetic overflow or nonzero tag raises type 0x0A, priority 14.
// RULE20: Divide by zero raises type 0x2A, priority 15.
// RULE21: True conditional software trap raises type 0x80 to 0xFF, priority 16.
// RULE22: Up to 15 interrupt requests are prioritised and forwarded to the pipeline.
// RULE23: Highest pending at high level wins; else highest pending at low level.
// RULE24: Interrupt 15 ignores the processor interrupt level threshold.
// RULE25: Acknowledge clears the pending bit, or the force bit if forced.
// RULE26: Non-reset traps write their type into the trap type field.
// RULE27: Interrupt at level n uses trap type 0x10 plus n.
`timescale 1ns/1ps
`default_nettype none

module tpu_trap_unit #(
  parameter int NUM_WIN = 8
) (
  input  wire logic                       core_clk_i,
  input  wire logic                       reset_i,
  input  wire logic                       processor_reset_n_i,
  input  wire tpu_pkg::tpu_event_s        event_i,
  input  wire logic [15:1]                irq_i,
  output logic [3:0]                      irq_level_o,
  output tpu_pkg::tpu_trap_s              trap_o,
  output logic [$clog2(NUM_WIN)-1:0]      current_window_pointer_o,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [7:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic [31:0]                     wb_dat_o,
  output logic                            wb_ack_o
);

  localparam int WW = $clog2(NUM_WIN);

  function automatic logic [WW-1:0] win_dec(input logic [WW-1:0] w);
    win_dec = (w == '0) ? WW'(NUM_WIN - 1) : WW'(w - 1'b1);
  endfunction

  function automatic logic [WW-1:0] win_inc(input logic [WW-1:0] w);
    win_inc = (w == WW'(NUM_WIN - 1)) ? '0 : WW'(w + 1'b1);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction

  function automatic logic [3:0] top_bit(input logic [15:1] v);
    top_bit = '0;
    for (int i = 1; i <= 15; i++) begin
      if (v[i]) top_bit = 4'(i);
    end
  endfunction

  function automatic logic [31:0] vec(input logic [19:0] base, input logic [7:0] tt);
    vec = {base, tt, 4'h0};
  endfunction

  // Software-visible state, plus reset edge, bus answer and trap output flops
  logic [19:0]     tbr_base_r;
  logic [7:0]      trap_type_field_r;
  logic [WW-1:0]   cwp_r;
  logic [NUM_WIN-1:0] wim_r;
  logic            supervisor_flag_r;
  logic            fp_enable_r;
  logic [3:0]      pil_r;
  logic [4:0]      fp_tem_r;
  logic [2:0]      fp_ftt_r;
  logic [15:1]     pend_r;
  logic [15:1]     force_r;
  logic [15:1]     level_r;
  logic [15:1]     mask_r;
  logic [31:2]     watch_addr_r;
  logic            watch_en_r;
  logic            proc_prev_r;
  logic            ack_r;
  logic [31:0]     dat_r;
  tpu_pkg::tpu_trap_s trap_r;

  // Bus decode
  logic        req;
  logic [31:0] rd_mux;
  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  logic [31:0] tbr_wr;
  assign tbr_wr = merge({tbr_base_r, 12'h000}, wb_dat_i, wb_sel_i);

  function automatic logic wr_hit(input logic r, input logic we, input logic [7:0] a,
                                  input logic [7:0] ofs);
    wr_hit = r & we & (a == ofs);
  endfunction

  // Synchronous trap classification
  logic       sync_hit;
  logic [7:0] sync_tt;
  logic [2:0] ftt_kind;
  logic       watch_hit;
  logic       mis_hit;
  logic [1:0] acc_size;
  logic [WW-1:0] save_w;
  logic [WW-1:0] rest_w;

  assign save_w    = win_dec(cwp_r);
  assign rest_w    = win_inc(cwp_r);
  assign watch_hit = watch_en_r & ((event_i.fetch_addr[31:2] == watch_addr_r) |
                     (event_i.mem_op & (event_i.mem_addr[31:2] == watch_addr_r))); // see RULE13
  assign acc_size  = event_i.jmp_op ? tpu_pkg::SIZE_WORD : event_i.mem_size;
  assign mis_hit   = (event_i.mem_op | event_i.jmp_op) &
                     ((event_i.mem_addr[2:0] & ((3'h1 << acc_size) - 3'h1)) != 3'h0); // see RULE16

  // Chain order is priority order, so lower priorities are dropped  // see RULE4
  always_comb begin
    sync_hit = event_i.instr_valid; // see RULE3
    sync_tt  = '0;
    ftt_kind = tpu_pkg::FTT_NONE;
    if (!event_i.instr_valid) begin
      sync_hit = 1'b0;
    end else if (event_i.wr_buf_err) begin
      sync_tt = tpu_pkg::TT_WRITE_ERR; // see RULE7
    end else if (event_i.fetch_err) begin
      sync_tt = tpu_pkg::TT_FETCH_ERR; // see RULE8
    end else if (event_i.priv_op && !supervisor_flag_r) begin
      sync_tt = tpu_pkg::TT_PRIV; // see RULE10
    end else if (event_i.illegal_op) begin
      sync_tt = tpu_pkg::TT_ILLEGAL; // see RULE9
    end else if (event_i.fp_op && !fp_enable_r) begin
      sync_tt = tpu_pkg::TT_FP_DIS; // see RULE11
    end else if (event_i.cp_op) begin
      sync_tt = tpu_pkg::TT_CP_DIS; // see RULE12
    end else if (watch_hit) begin
      sync_tt = tpu_pkg::TT_WATCH; // see RULE13
    end else if (event_i.save_op && wim_r[save_w]) begin
      sync_tt = tpu_pkg::TT_WIN_OVF; // see RULE14
    end else if (event_i.restore_op && wim_r[rest_w]) begin
      sync_tt = tpu_pkg::TT_WIN_UNF; // see RULE14
    end else if (event_i.reg_err) begin
      sync_tt = tpu_pkg::TT_REG_ERR; // see RULE15
    end else if (mis_hit) begin
      sync_tt = tpu_pkg::TT_ALIGN; // see RULE16
    end else if (event_i.fp_op && ((event_i.fp_ieee_exc & fp_tem_r) != '0 ||
                 event_i.fp_unimp || event_i.fp_unfinished || event_i.fp_seq_err)) begin
      sync_tt = tpu_pkg::TT_FP_EXC; // see RULE17
      if (event_i.fp_seq_err) ftt_kind = tpu_pkg::FTT_SEQ;
      else if (event_i.fp_unimp) ftt_kind = tpu_pkg::FTT_UNIMP;
      else if (event_i.fp_unfinished) ftt_kind = tpu_pkg::FTT_UNFINISHED;
      else ftt_kind = tpu_pkg::FTT_IEEE;
    end else if (event_i.data_err) begin
      sync_tt = tpu_pkg::TT_DATA_ERR; // see RULE18
    end else if (event_i.tag_op && (event_i.tag_ovf || event_i.tag_a != '0 ||
                 event_i.tag_b != '0)) begin
      sync_tt = tpu_pkg::TT_TAG_OVF; // see RULE19
    end else if (event_i.div_op && event_i.divisor == '0) begin
      sync_tt = tpu_pkg::TT_DIV_ZERO; // see RULE20
    end else if (event_i.ticc_op && event_i.ticc_true) begin
      sync_tt = tpu_pkg::TT_SOFT_BASE | {1'b0, event_i.ticc_num}; // see RULE21
    end else begin
      sync_hit = 1'b0;
    end
  end

  // Interrupt selection
  logic [15:1] eff;
  logic [3:0]  irq_lvl;
  logic        irq_ok;
  assign eff     = (pend_r | force_r) & ~mask_r; // see RULE22
  assign irq_lvl = (|(eff & level_r)) ? top_bit(eff & level_r) : top_bit(eff & ~level_r); // see RULE23
  assign irq_ok  = event_i.boundary && irq_lvl != '0 &&
                   (irq_lvl == tpu_pkg::IRQ_NMI_LEVEL || irq_lvl > pil_r); // see RULE24
  assign irq_level_o = irq_lvl; // see RULE22

  logic       take_reset;
  logic       take_sync;
  logic       take_irq;
  logic [7:0] take_tt;
  assign take_reset = processor_reset_n_i & ~proc_prev_r; // see RULE5
  assign take_sync  = processor_reset_n_i & ~take_reset & sync_hit;
  assign take_irq   = processor_reset_n_i & ~take_reset & ~sync_hit & irq_ok; // see RULE3
  assign take_tt    = take_sync ? sync_tt : (tpu_pkg::TT_IRQ_BASE + {4'h0, irq_lvl}); // see RULE27

  always_ff @(posedge core_clk_i) begin
    if (reset_i) proc_prev_r <= 1'b0;
    else proc_prev_r <= processor_reset_n_i;
  end

  // Trap base register
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      tbr_base_r        <= '0;
      trap_type_field_r <= '0;
    end else begin
      if (wr_hit(req, wb_we_i, wb_adr_i, tpu_pkg::OFS_TRAP_BASE)) begin
        tbr_base_r <= tbr_wr[31:tpu_pkg::TBR_BASE_LSB];
      end
      if (take_sync || take_irq) trap_type_field_r <= take_tt; // see RULE26 RULE6
    end
  end

  // Window pointer and invalid mask
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cwp_r <= '0;
      wim_r <= '0;
    end else begin
      if (take_reset || take_sync || take_irq) cwp_r <= save_w; // see RULE2
      else if (event_i.instr_valid && event_i.save_op) cwp_r <= save_w;
      else if (event_i.instr_valid && event_i.restore_op) cwp_r <= rest_w;
      else if (wr_hit(req, wb_we_i, wb_adr_i, tpu_pkg::OFS_WINDOW)) cwp_r <= wb_dat_i[WW-1:0];
      if (wr_hit(req, wb_we_i, wb_adr_i, tpu_pkg::OFS_WIN_MASK)) wim_r <= wb_dat_i[NUM_WIN-1:0];
    end
  end
  assign current_window_pointer_o = cwp_r;

  // Processor and floating-point state
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      supervisor_flag_r <= 1'b1;
      fp_enable_r       <= 1'b0;
      pil_r             <= '0;
      fp_tem_r          <= '0;
      fp_ftt_r          <= tpu_pkg::FTT_NONE;
    end else begin
      if (wr_hit(req, wb_we_i, wb_adr_i, tpu_pkg::OFS_PROC_STATE)) begin
        supervisor_flag_r <= wb_dat_i[tpu_pkg::PS_SUPER_BIT];
        fp_enable_r       <= wb_dat_i[tpu_pkg::PS_FP_EN_BIT];
        pil_r             <= wb_dat_i[tpu_pkg::PS_PIL_LSB +: 4];
      end
      if (take_reset || take_sync || take_irq) supervisor_flag_r <= 1'b1; // see RULE1
      if (wr_hit(req, wb_we_i, wb_adr_i, tpu_pkg::OFS_FP_STATE)) fp_tem_r <= wb_dat_i[4:0];
      if (take_sync && sync_tt == tpu_pkg::TT_FP_EXC) fp_ftt_r <= ftt_kind; // see RULE17
    end
  end

  // Interrupt controller; a new request beats a clear in the same cycle
  logic irq_ack_force;
  assign irq_ack_force = take_irq & force_r[irq_lvl];
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      pend_r  <= '0;
      force_r <= '0;
      level_r <= '0;
      mask_r  <= '1;
    end else begin
      for (int i = 1; i <= 15; i++) begin
        if (irq_i[i] && !mask_r[i]) pend_r[i] <= 1'b1;
        else if ((take_irq && !irq_ack_force && irq_lvl == 4'(i)) || // see RULE25
                 (wr_hit(req, wb_we_i, wb_adr_i, tpu_pkg::OFS_IRQ_PEND) && wb_dat_i[i])) begin
          pend_r[i] <= 1'b0;
        end
        if (wr_hit(req, wb_we_i, wb_adr_i, tpu_pkg::OFS_IRQ_FORCE)) force_r[i] <= wb_dat_i[i];
        else if (irq_ack_force && irq_lvl == 4'(i)) force_r[i] <= 1'b0; // see RULE25
      end
      if (wr_hit(req, wb_we_i, wb_adr_i, tpu_pkg::OFS_IRQ_LEVEL)) level_r <= wb_dat_i[15:1];
      if (wr_hit(req, wb_we_i, wb_adr_i, tpu_pkg::OFS_IRQ_MASK)) mask_r <= wb_dat_i[15:1];
    end
  end

  // Watchpoint
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      watch_addr_r <= '0;
      watch_en_r   <= 1'b0;
    end else if (wr_hit(req, wb_we_i, wb_adr_i, tpu_pkg::OFS_WATCH)) begin
      watch_addr_r <= wb_dat_i[31:2];
      watch_en_r   <= wb_dat_i[0];
    end
  end

  // Trap output; reset vectors to the table base itself
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      trap_r <= '0;
    end else begin
      trap_r.taken    <= take_reset | take_sync | take_irq;
      trap_r.is_reset <= take_reset;
      trap_r.is_irq   <= take_irq;
      trap_r.tt       <= take_reset ? trap_type_field_r : take_tt;
      trap_r.vector   <= take_reset ? vec(tbr_base_r, 8'h00) : vec(tbr_base_r, take_tt); // see RULE1
      trap_r.pc       <= event_i.pc; // see RULE2
      trap_r.next_program_counter      <= event_i.next_program_counter; // see RULE2
    end
  end
  assign trap_o = trap_r;

  // Wishbone read mux and single-cycle answer
  always_comb begin
    rd_mux = '0;
    unique case (wb_adr_i)
      tpu_pkg::OFS_TRAP_BASE:  rd_mux = vec(tbr_base_r, trap_type_field_r);
      tpu_pkg::OFS_WINDOW:     rd_mux[WW-1:0] = cwp_r;
      tpu_pkg::OFS_WIN_MASK:   rd_mux[NUM_WIN-1:0] = wim_r;
      tpu_pkg::OFS_PROC_STATE: begin
        rd_mux[tpu_pkg::PS_SUPER_BIT]    = supervisor_flag_r;
        rd_mux[tpu_pkg::PS_FP_EN_BIT]    = fp_enable_r;
        rd_mux[tpu_pkg::PS_PIL_LSB +: 4] = pil_r;
      end
      tpu_pkg::OFS_FP_STATE:   rd_mux = {21'h0, fp_ftt_r, 3'h0, fp_tem_r};
      tpu_pkg::OFS_IRQ_PEND:   rd_mux[15:1] = pend_r;
      tpu_pkg::OFS_IRQ_FORCE:  rd_mux[15:1] = force_r;
      tpu_pkg::OFS_IRQ_LEVEL:  rd_mux[15:1] = level_r;
      tpu_pkg::OFS_IRQ_MASK:   rd_mux[15:1] = mask_r;
      tpu_pkg::OFS_WATCH:      rd_mux = {watch_addr_r, 1'b0, watch_en_r};
      tpu_pkg::OFS_STATUS:     rd_mux = {20'h0, irq_lvl, trap_r.tt};
      default:                 rd_mux = '0;
    endcase
  end

  // Unmapped addresses still answer, reading zero, so a stray access cannot hang the bus
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ack_r <= req;
      if (req && !wb_we_i) dat_r <= rd_mux;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // Checks
  property p_reset_trap; // see RULE5
    @(posedge core_clk_i) disable iff (reset_i)
      (processor_reset_n_i && !proc_prev_r) |=> (trap_o.taken && trap_o.is_reset);
  endproperty
  a_reset_trap: assert property (p_reset_trap) else $error("reset trap missing");

  property p_reset_keeps_tt; // see RULE6
    @(posedge core_clk_i) disable iff (reset_i)
      take_reset |=> (trap_type_field_r == $past(trap_type_field_r));
  endproperty
  a_reset_keeps_tt: assert property (p_reset_keeps_tt) else $error("reset changed type");

  property p_tt_written; // see RULE26
    @(posedge core_clk_i) disable iff (reset_i)
      (take_sync || take_irq) |=> (trap_type_field_r == trap_o.tt);
  endproperty
  a_tt_written: assert property (p_tt_written) else $error("type field not written");

  property p_vector; // see RULE1
    @(posedge core_clk_i) disable iff (reset_i)
      (trap_o.taken && !trap_o.is_reset) |-> (trap_o.vector[31:0] == vec(tbr_base_r, trap_o.tt));
  endproperty
  a_vector: assert property (p_vector) else $error("bad handler address");

  property p_window; // see RULE2
    @(posedge core_clk_i) disable iff (reset_i)
      (take_sync || take_irq) |=> (cwp_r == win_dec($past(cwp_r)) && trap_o.pc == $past(event_i.pc));
  endproperty
  a_window: assert property (p_window) else $error("window or pc not saved");

  property p_write_err_first; // see RULE7
    @(posedge core_clk_i) disable iff (reset_i)
      (take_sync && event_i.wr_buf_err) |=> (trap_o.tt == tpu_pkg::TT_WRITE_ERR);
  endproperty
  a_write_err_first: assert property (p_write_err_first) else $error("write error lost");

  property p_irq_between; // see RULE3
    @(posedge core_clk_i) disable iff (reset_i)
      (trap_o.taken && trap_o.is_irq) |-> ($past(event_i.boundary) && !$past(sync_hit));
  endproperty
  a_irq_between: assert property (p_irq_between) else $error("interrupt inside instruction");

  property p_irq15; // see RULE24
    @(posedge core_clk_i) disable iff (reset_i)
      (irq_lvl == tpu_pkg::IRQ_NMI_LEVEL && event_i.boundary && !sync_hit &&
       processor_reset_n_i && proc_prev_r) |=> (trap_o.taken && trap_o.tt == 8'h1F);
  endproperty
  a_irq15: assert property (p_irq15) else $error("level 15 blocked");

  property p_ack_clear; // see RULE25
    @(posedge core_clk_i) disable iff (reset_i)
      (take_irq && !irq_ack_force && !irq_i[irq_lvl]) |=> !pend_r[$past(irq_lvl)];
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("pending not cleared");

  property p_div; // see RULE20
    @(posedge core_clk_i) disable iff (reset_i)
      (take_sync && sync_tt == tpu_pkg::TT_DIV_ZERO) |=> (trap_o.tt == 8'h2A) ##1 !trap_o.is_reset;
  endproperty
  a_div: assert property (p_div) else $error("divide trap wrong");

endmodule

`default_nettype wire

// >>> tpu_pipe_model.sv
// Pipeline stand-in: turns a cause code into one cycle of instruction events.
// Assumes the bench changes cause_i right after a core clock edge.
`timescale 1ns/1ps
`default_nettype none
module tpu_pipe_model (
  input  wire logic [3:0]     cause_i,
  input  wire logic [31:0]    pc_i,
  output tpu_pkg::tpu_event_s event_o
);
  always_comb begin
    event_o             = '0;
    event_o.instr_valid = (cause_i != 4'h0) && (cause_i != 4'hF);
    event_o.boundary    = (cause_i == 4'hF);
    event_o.pc          = pc_i;
    event_o.next_program_counter         = pc_i + 32'h0000_0004;
    event_o.divisor     = 32'h0000_0001;
    event_o.mem_size    = tpu_pkg::SIZE_WORD;
    event_o.ticc_num    = pc_i[8:2];
    case (cause_i)
      4'h1: event_o.wr_buf_err = 1'b1;
      4'h2: event_o.fetch_err = 1'b1;
      4'h3: event_o.illegal_op = 1'b1;
      4'h4: event_o.priv_op = 1'b1;
      4'h5: event_o.fp_op = 1'b1;
      4'h6: event_o.cp_op = 1'b1;
      4'h7: event_o.reg_err = 1'b1;
      // Word access at a half-word offset
      4'h8: event_o.mem_op = 1'b1;
      4'h9: event_o.data_err = 1'b1;
      4'hA: event_o.tag_a = 2'h1;
      4'hB: event_o.div_op = 1'b1;
      4'hC: event_o.ticc_true = 1'b1;
      4'hE: event_o.save_op = 1'b1;
      default: ;
    endcase
    event_o.mem_addr  = (cause_i == 4'h8) ? 32'h0000_0102 : 32'h0000_0100;
    event_o.tag_op    = (cause_i == 4'hA);
    event_o.ticc_op   = (cause_i == 4'hC);
    // Several causes at once: only the write error may win
    if (cause_i == 4'hD) begin
      event_o.wr_buf_err = 1'b1;
      event_o.fetch_err  = 1'b1;
      event_o.data_err   = 1'b1;
      event_o.div_op     = 1'b1;
    end
    if (cause_i == 4'hB || cause_i == 4'hD) event_o.divisor = '0;
  end
endmodule
`default_nettype wire

// >>> trap_priority_unit_tb_top.sv
// Self-checking bench for the trap unit: queue model of expected trap types.
// Assumes the pipeline model file is compiled before this one.
`timescale 1ns/1ps
`default_nettype none
module trap_priority_unit_tb_top;
  localparam logic [31:0] BASE = 32'h0004_0000;
  logic                clk = 0, rst = 1, prn = 1, cyc = 0, stb = 0, we = 0, ack;
  logic [3:0]          cause = 0, lvl;
  logic [31:0]         pc = 0, q, dat = 0, rdat;
  logic [15:1]         irq = 0;
  logic [7:0]          adr = 0;
  logic [2:0]          current_window_pointer;
  tpu_pkg::tpu_event_s ev;
  tpu_pkg::tpu_trap_s  tr;
  int                  err_count = 0, tests_run = 0, seed = 26597, cwp_m, ttq[$];
  logic [7:0]          tt_tab[1:13] = '{8'h2B, 8'h01, 8'h02, 8'h03, 8'h04, 8'h24, 8'h20,
                                        8'h07, 8'h09, 8'h0A, 8'h2A, 8'h00, 8'h2B};
  tpu_pipe_model pipe_u (.cause_i(cause), .pc_i(pc), .event_o(ev));
  tpu_trap_unit #(.NUM_WIN(8)) dut_u (.core_clk_i(clk), .reset_i(rst),
    .processor_reset_n_i(prn), .event_i(ev), .irq_i(irq), .irq_level_o(lvl), .trap_o(tr),
    .current_window_pointer_o(current_window_pointer), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack));
  initial forever #10 clk = ~clk;
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    stop_test;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Classic single cycle; request held until ack is seen at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1 && ++n < 20);
    chk(ack, 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wait_taken;
    int n;
    n = 0;
    do @(negedge clk); while (tr.taken !== 1'b1 && ++n < 20);
    chk(tr.taken, 1'b1);
  endtask
  task automatic settle;
    int e;
    wait_taken;
    e = ttq.pop_front();
    chk(tr.tt, e);
    chk(tr.vector, BASE | (e << 4));
    cwp_m = (cwp_m + 7) % 8;
    chk(current_window_pointer, cwp_m);
    chk(tr.pc, pc);
  endtask
  // One cycle of cause c, expected trap type e
  task automatic fire(input logic [3:0] c, input logic [7:0] e);
    @(posedge clk);
    cause <= c;
    @(posedge clk);
    cause <= 4'h0;
    ttq.push_back(e);
    settle;
    $display("cause %0h done", c);
  endtask
  // Interrupt pulse m, expected winner n, processor state ps
  task automatic irq_go(input logic [15:0] m, input int n, input logic [31:0] ps);
    wb(1'b1, 8'h0C, ps);
    @(posedge clk);
    irq <= m[15:1];
    @(posedge clk);
    irq <= '0;
    @(negedge clk);
    chk(lvl, n);
    @(posedge clk);
    cause <= 4'hF;
    @(posedge clk);
    cause <= 4'h0;
    ttq.push_back(8'h10 + n);
    settle;
    wb(1'b0, 8'h14, 32'h0);
    chk(q, {16'h0, m & ~(16'h1 << n)});
    wb(1'b1, 8'h14, 32'h0000_FFFE);
    $display("interrupt %0d done", n);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wait_taken;
    chk(tr.is_reset, 1'b1);
    wb(1'b1, 8'h00, BASE);
    wb(1'b1, 8'h04, 32'h3);
    cwp_m = 3;
    wb(1'b0, 8'hFC, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 8'h00, 32'h0);
    chk(q, BASE);
    for (int k = 1; k <= 13; k++) begin
      if (k == 4) wb(1'b1, 8'h0C, 32'h0);
      @(posedge clk);
      cause <= k[3:0];
      pc <= $random(seed) & 32'hFFFF_FFFC;
      @(posedge clk);
      cause <= 4'h0;
      ttq.push_back(k == 12 ? {1'b1, pc[8:2]} : tt_tab[k]);
      settle;
      $display("cause %0d done", k);
    end
    // Watchpoint on word 0 outranks the register file error
    wb(1'b1, 8'h24, 32'h0000_0001);
    fire(4'h7, 8'h0B);
    wb(1'b1, 8'h24, 32'h0);
    wb(1'b1, 8'h08, 32'h0000_00FF);
    fire(4'hE, 8'h05);
    wb(1'b1, 8'h08, 32'h0);
    wb(1'b1, 8'h20, 32'h0);
    irq_go(16'h0020, 5, 32'h0000_0001);
    wb(1'b1, 8'h1C, 32'h0000_0008);
    irq_go(16'h0208, 3, 32'h0000_0001);
    irq_go(16'h8000, 15, 32'h0000_0F01);
    @(posedge clk);
    prn <= 1'b0;
    @(posedge clk);
    prn <= 1'b1;
    wait_taken;
    chk(tr.is_reset, 1'b1);
    chk(tr.tt, 8'h1F);
    $display("reset trap done");
    stop_test;
  end
endmodule
`default_nettype wire
